/* File: shared/vomc_pkg.sv */
// Purpose: Constants for the video output mode control register bank.
// Assumes: Register indices are multiplied by four to form APB byte addresses.
// Notes: Only the low byte of each 32-bit APB word carries register data.
package vomc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PORT_SEL = 8'h34;
  localparam logic [7:0] IDX_TX_MODE = 8'h49;
  localparam logic [7:0] IDX_SWING = 8'h4B;
  localparam logic [7:0] IDX_MON_SRC = 8'h52;
  localparam logic [7:0] IDX_MON_EN = 8'h56;
  localparam logic [7:0] IDX_MON_SRC2 = 8'h57;

  // APB address layout.
  localparam int unsigned PADDR_W = 12;
  localparam int unsigned PDATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Field positions.
  localparam int unsigned POS_STRAP_SEL = 7;
  localparam int unsigned POS_OVR_EN = 6;
  localparam int unsigned POS_REG_SEL = 5;
  localparam int unsigned POS_MODE_LO = 0;
  localparam int unsigned POS_PORT1 = 0;
  localparam int unsigned POS_MON_BIT = 7;
  localparam int unsigned POS_MON_EN = 3;
  localparam int unsigned POS_MON_FIELD_LO = 1;

  // Reset values.
  localparam logic RST_OVR_EN = 1'h0;
  localparam logic RST_REG_SEL = 1'h0;
  localparam logic RST_PORT_SEL = 1'h0;
  localparam logic [7:0] RST_SWING = 8'h00;
  localparam logic RST_MON_BIT = 1'h0;
  localparam logic RST_MON_EN = 1'h0;
  localparam logic [1:0] RST_MON_FIELD = 2'h0;

  // Display output arrangement codes.
  localparam logic [1:0] MODE_DUAL = 2'h0;
  localparam logic [1:0] MODE_DUAL_SWAP = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_REPLICATE = 2'h3;

  // Output swing codes, lowest (190 mV) to highest (375 mV).
  localparam logic [1:0] SWING_190MV = 2'h0;
  localparam logic [1:0] SWING_375MV = 2'h3;

  // Monitor source field codes.
  localparam logic [1:0] FIELD_LANE0 = 2'h1;
  localparam logic [1:0] FIELD_LANE1 = 2'h2;

  // Strap code width: {map select, arrangement[1:0]}.
  localparam int unsigned STRAP_W = 3;

  // True when the index names a register of this bank.
  function automatic logic vomc_is_mapped(input logic [7:0] idx);
    return (idx == IDX_PORT_SEL) || (idx == IDX_TX_MODE) || (idx == IDX_SWING) ||
           (idx == IDX_MON_SRC) || (idx == IDX_MON_EN) || (idx == IDX_MON_SRC2);
  endfunction : vomc_is_mapped

  // Lane chosen for the monitor: the field wins when it holds a legal code.
  function automatic logic vomc_pick_lane(input logic sel_bit, input logic [1:0] field);
    if (field == FIELD_LANE1) begin
      return 1'b1;
    end else if (field == FIELD_LANE0) begin
      return 1'b0;
    end
    return sel_bit;
  endfunction : vomc_pick_lane

endpackage : vomc_pkg

/* File: shared/vomc_reg_if.sv */
// Purpose: Carries register accesses from the bus slave to the bank.
// Assumes: One write strobe per completed APB write to a mapped word with byte lane 0 enabled; none otherwise.
// Notes: Read data is combinational from the bank.
`timescale 1ns/1ps
interface vomc_reg_if;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr_en, output idx, output wdata, input rdata);
  modport bank (input wr_en, input idx, input wdata, output rdata);
endinterface : vomc_reg_if

/* File: design/vomc_apb_slave.sv */
// Purpose: APB slave that turns transfers into register strobes.
// Assumes: Masters hold the request until pready is sampled high.
// Notes: Every transfer takes two access cycles; unmapped words answer pslverr.
`timescale 1ns/1ps
module vomc_apb_slave
  import vomc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [PADDR_W-1:0] i_paddr,
  input wire logic [PDATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [PDATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  vomc_reg_if.bus reg_bus
);

  // Address decode and access phase detection.
  wire access = i_psel & i_penable;
  wire first_access = access & ~o_pready;
  wire aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[PADDR_W-1:10] == 2'h0);
  wire [7:0] index = i_paddr[9:2];
  wire hit = aligned & vomc_is_mapped(index);

  // The write lands on the completing edge only, and only with lane 0 enabled.
  assign reg_bus.idx = index;
  assign reg_bus.wdata = i_pwdata[REG_W-1:0];
  assign reg_bus.wr_en = access & o_pready & i_pwrite & hit & i_pstrb[0];

  // Ready, read data and error are registered one cycle into the access.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= first_access;
      o_prdata <= (first_access & ~i_pwrite & hit) ? {24'h00_0000, reg_bus.rdata} : 32'h0000_0000;
      o_pslverr <= first_access & ~hit;
    end
  end

endmodule : vomc_apb_slave

/* File: design/vomc_pin_sync.sv */
// Purpose: Three-stage synchroniser for the strap code pins.
// Assumes: The strap level is static for several cycles around reset.
// Notes: The held level changes only when stages two and three agree.
`timescale 1ns/1ps
module vomc_pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic i_clk_sys,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Pipeline runs through reset so the level is settled at release.
  always_ff @(posedge i_clk_sys) begin
    stage1 <= i_pin;
    stage2 <= stage1;
    stage3 <= stage2;
    if (stage2 == stage3) begin
      o_level <= stage3;
    end
  end

endmodule : vomc_pin_sync

/* File: design/vomc_regs.sv */
// Purpose: Output mode, swing and monitor control registers behind APB.
// Assumes: Reset is held at least four clock edges so the strap has settled.
// Notes: Recovered lane data comes from logic on the same clock.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

// Summary of operation
// - Read-only bit shows strapped map select.
// - Override enable bit, reset zero.
// - Override set: register bit becomes map select.
// - Two-bit arrangement: dual, swapped, single, replicated.
// - Arrangement loads from strap at reset.
// - Two-bit swing code, reset zero, four levels; each port register keeps all eight written bits.
// - Monitor source bit picks lane zero or one.
// - Monitor enable bit gates driver, reset off.
// - Field code 01 lane zero, 10 lane one.
module vomc_regs
  import vomc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [PADDR_W-1:0] i_paddr,
  input wire logic [PDATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [PDATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [STRAP_W-1:0] i_mode_strap_pin_zero,
  input wire logic i_serial_input_lane_zero,
  input wire logic i_serial_input_lane_one,
  output logic [1:0] o_display_output_arrangement,
  output logic o_map_select,
  output logic [REG_W-1:0] o_output_swing_code_port0,
  output logic [REG_W-1:0] o_output_swing_code_port1,
  output logic o_monitor_driver_enable,
  output logic o_loop_through_monitor_output
);

  vomc_reg_if reg_bus ();

  logic [STRAP_W-1:0] strap_level;
  logic strap_pending;
  logic strap_sel;
  logic ovr_en;
  logic reg_sel;
  logic second_port_select;
  logic monitor_source_bit;
  logic [1:0] monitor_source_field;

  // Bus slave; all APB outputs come from its flip-flops.
  vomc_apb_slave u_apb (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .reg_bus(reg_bus.bus)
  );

  // Strap pins cross into the clock domain through three stages.
  vomc_pin_sync #(
    .WIDTH(STRAP_W)
  ) u_strap_sync (
    .i_clk_sys(i_clk_sys),
    .i_pin(i_mode_strap_pin_zero),
    .o_level(strap_level)
  );

  // Write strobes per register.
  wire wr_port = reg_bus.wr_en && (reg_bus.idx == IDX_PORT_SEL);
  wire wr_mode = reg_bus.wr_en && (reg_bus.idx == IDX_TX_MODE);
  wire wr_swing = reg_bus.wr_en && (reg_bus.idx == IDX_SWING);
  wire wr_src = reg_bus.wr_en && (reg_bus.idx == IDX_MON_SRC);
  wire wr_en_reg = reg_bus.wr_en && (reg_bus.idx == IDX_MON_EN);
  wire wr_src2 = reg_bus.wr_en && (reg_bus.idx == IDX_MON_SRC2);
  wire [7:0] wd = reg_bus.wdata;

  // Effective map select and selected monitor lane.
  wire next_map_select = ovr_en ? reg_sel : strap_sel;
  wire mon_lane = vomc_pick_lane(monitor_source_bit, monitor_source_field);
  wire lane_data = mon_lane ? i_serial_input_lane_one : i_serial_input_lane_zero;
  wire next_monitor_out = o_monitor_driver_enable & lane_data;

  // Register images; reserved bits are constant zero, except in the swing image, which returns all eight stored bits.
  wire [7:0] img_port = {7'h00, second_port_select};
  wire [7:0] img_mode = {strap_sel, ovr_en, reg_sel, 3'h0,
                         o_display_output_arrangement};
  wire [7:0] img_swing = second_port_select ? o_output_swing_code_port1 :
                         o_output_swing_code_port0;
  wire [7:0] img_src = {monitor_source_bit, 7'h00};
  wire [7:0] img_en = {4'h0, o_monitor_driver_enable, 3'h0};
  wire [7:0] img_src2 = {5'h00, monitor_source_field, 1'h0};

  // Read multiplexer.
  assign reg_bus.rdata = (reg_bus.idx == IDX_PORT_SEL) ? img_port :
                         (reg_bus.idx == IDX_TX_MODE) ? img_mode :
                         (reg_bus.idx == IDX_SWING) ? img_swing :
                         (reg_bus.idx == IDX_MON_SRC) ? img_src :
                         (reg_bus.idx == IDX_MON_EN) ? img_en :
                         (reg_bus.idx == IDX_MON_SRC2) ? img_src2 : 8'h00;

  // Strap capture happens on the first edge after reset is released.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      strap_pending <= 1'b1;
      strap_sel <= 1'b0;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      strap_sel <= strap_level[STRAP_W-1];
    end
  end

  // Arrangement field: strap loads on the first edge after reset; a write wins over it in that cycle and at any time after.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_display_output_arrangement <= MODE_DUAL;
    end else if (wr_mode) begin
      o_display_output_arrangement <= wd[POS_MODE_LO+:2];
    end else if (strap_pending) begin
      o_display_output_arrangement <= strap_level[1:0];
    end
  end

  // Override controls for the map select.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ovr_en <= RST_OVR_EN;
      reg_sel <= RST_REG_SEL;
    end else if (wr_mode) begin
      ovr_en <= wd[POS_OVR_EN];
      reg_sel <= wd[POS_REG_SEL];
    end
  end

  // Port select steers which port's swing register is reached.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      second_port_select <= RST_PORT_SEL;
    end else if (wr_port) begin
      second_port_select <= wd[POS_PORT1];
    end
  end

  // Swing registers, one per output port.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_output_swing_code_port0 <= RST_SWING;
      o_output_swing_code_port1 <= RST_SWING;
    end else if (wr_swing && second_port_select) begin
      o_output_swing_code_port1 <= wd;
    end else if (wr_swing) begin
      o_output_swing_code_port0 <= wd;
    end
  end

  // Monitor source and enable controls.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      monitor_source_bit <= RST_MON_BIT;
      monitor_source_field <= RST_MON_FIELD;
      o_monitor_driver_enable <= RST_MON_EN;
    end else begin
      if (wr_src) begin
        monitor_source_bit <= wd[POS_MON_BIT];
      end
      if (wr_src2) begin
        monitor_source_field <= wd[POS_MON_FIELD_LO+:2];
      end
      if (wr_en_reg) begin
        o_monitor_driver_enable <= wd[POS_MON_EN];
      end
    end
  end

  // Registered outputs derived from the controls.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_map_select <= 1'b0;
      o_loop_through_monitor_output <= 1'b0;
    end else begin
      o_map_select <= next_map_select;
      o_loop_through_monitor_output <= next_monitor_out;
    end
  end

  // Checks on the bank's behaviour.
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  strap_status_a: assert property (
    strap_pending |=> (strap_sel == $past(strap_level[STRAP_W-1])) && !strap_pending
  ) else $error("strapped map select not captured after reset");

  ovr_reset_a: assert property (
    $fell(i_sys_rst) |-> !ovr_en && !reg_sel
  ) else $error("override controls not zero after reset");

  map_select_a: assert property (
    ##1 (o_map_select == ($past(ovr_en) ? $past(reg_sel) : $past(strap_sel)))
  ) else $error("effective map select wrong");

  mode_write_a: assert property (
    wr_mode |=> (o_display_output_arrangement == $past(wd[1:0]))
  ) else $error("arrangement write not applied");

  mode_strap_a: assert property (
    (strap_pending && !wr_mode) |=> (o_display_output_arrangement == $past(strap_level[1:0]))
  ) else $error("arrangement not loaded from strap");

  swing_reset_a: assert property (
    $fell(i_sys_rst) |-> (o_output_swing_code_port0[1:0] == SWING_190MV)
  ) else $error("swing code not reset to lowest level");

  swing_port_a: assert property (
    (wr_swing && second_port_select) |=> $stable(o_output_swing_code_port0) &&
      (o_output_swing_code_port1 == $past(wd))
  ) else $error("second port swing write misrouted");

  mon_route_a: assert property (
    (o_monitor_driver_enable && monitor_source_field == RST_MON_FIELD &&
     monitor_source_bit) |=> (o_loop_through_monitor_output == $past(i_serial_input_lane_one))
  ) else $error("monitor source bit routing wrong");

  mon_off_a: assert property (
    !o_monitor_driver_enable [*2] |-> !o_loop_through_monitor_output
  ) else $error("monitor output active while driver disabled");

  field_route_a: assert property (
    (o_monitor_driver_enable && monitor_source_field == FIELD_LANE0) |=>
      (o_loop_through_monitor_output == $past(i_serial_input_lane_zero))
  ) else $error("monitor field code 01 not routing lane zero");

  reserved_zero_a: assert property (
    (reg_bus.idx == IDX_MON_EN) |-> ((reg_bus.rdata & 8'hF7) == 8'h00)
  ) else $error("reserved bits of monitor enable read nonzero");

  // The strapped status bit never moves between resets.
  strap_hold_a: assert property (
    !strap_pending |=> $stable(strap_sel)
  ) else $error("strapped map select changed after capture");

  ovr_write_a: assert property (
    wr_mode |=> (ovr_en == $past(wd[POS_OVR_EN]))
  ) else $error("override enable write not applied");

  reg_sel_write_a: assert property (
    wr_mode |=> (reg_sel == $past(wd[POS_REG_SEL]))
  ) else $error("register map select write not applied");

  mode_hold_a: assert property (
    (!wr_mode && !strap_pending) |=> $stable(o_display_output_arrangement)
  ) else $error("arrangement changed without a write or strap load");

  swing_port0_a: assert property (
    (wr_swing && !second_port_select) |=> $stable(o_output_swing_code_port1) &&
      (o_output_swing_code_port0 == $past(wd))
  ) else $error("first port swing write misrouted");

  swing_hold_a: assert property (
    !wr_swing |=> $stable(o_output_swing_code_port0) && $stable(o_output_swing_code_port1)
  ) else $error("swing code changed without a write");

  src_bit_write_a: assert property (
    wr_src |=> (monitor_source_bit == $past(wd[POS_MON_BIT]))
  ) else $error("monitor source bit write not applied");

  mon_en_write_a: assert property (
    wr_en_reg |=> (o_monitor_driver_enable == $past(wd[POS_MON_EN]))
  ) else $error("monitor enable write not applied");

  mon_reset_a: assert property (
    $fell(i_sys_rst) |-> !o_monitor_driver_enable && !o_loop_through_monitor_output
  ) else $error("monitor driver not off after reset");

  field_write_a: assert property (
    wr_src2 |=> (monitor_source_field == $past(wd[POS_MON_FIELD_LO+:2]))
  ) else $error("monitor source field write not applied");

  lane_one_route_a: assert property (
    (o_monitor_driver_enable && monitor_source_field == FIELD_LANE1) |=>
      (o_loop_through_monitor_output == $past(i_serial_input_lane_one))
  ) else $error("monitor field code 10 not routing lane one");

  reserved_mode_a: assert property (
    (reg_bus.idx == IDX_TX_MODE) |-> (reg_bus.rdata[4:2] == 3'h0)
  ) else $error("reserved bits of output mode read nonzero");

  reserved_src_a: assert property (
    (reg_bus.idx == IDX_MON_SRC) |-> (reg_bus.rdata[6:0] == 7'h00)
  ) else $error("reserved bits of monitor source read nonzero");

  reserved_src2_a: assert property (
    (reg_bus.idx == IDX_MON_SRC2) |-> ((reg_bus.rdata & 8'hF9) == 8'h00)
  ) else $error("reserved bits of second monitor source read nonzero");

endmodule : vomc_regs

/* File: test/test_video_output_mode_control_regs.sv */
// Purpose: Self-checking bench for the output mode control register bank.
// Assumes: APB answers after two access cycles; strap is stable around reset.
// Notes: Each scenario is one task that drives APB and judges what returns.
`timescale 1ns/1ps
module test_video_output_mode_control_regs;
  import vomc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [PDATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [STRAP_W-1:0] strap = 3'h6;
  logic lane0 = 1'b0;
  logic lane1 = 1'b0;
  logic [PDATA_W-1:0] prdata;
  logic pready, pslverr, map_sel, mon_en, mon_out;
  logic [1:0] arr;
  logic [REG_W-1:0] sw0, sw1;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic err;

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  vomc_regs u_vomc_regs (.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_mode_strap_pin_zero(strap),
    .i_serial_input_lane_zero(lane0), .i_serial_input_lane_one(lane1),
    .o_display_output_arrangement(arr), .o_map_select(map_sel),
    .o_output_swing_code_port0(sw0), .o_output_swing_code_port1(sw1),
    .o_monitor_driver_enable(mon_en), .o_loop_through_monitor_output(mon_out));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("access cycles", n, 32'd1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Reads one register and compares data and error response.
  task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(name, rd, {24'h0, exp});
    chk("read pslverr", {31'h0, err}, 32'h0);
  endtask : rchk

  // Lets written values reach the outputs.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic t_reset_values();
    chk("strap arrangement", arr, 2'h2);
    chk("strap map select", map_sel, 1'b1);
    chk("monitor enable", mon_en, 1'b0);
    rchk("tx mode", IDX_TX_MODE, 8'h82);
    rchk("swing", IDX_SWING, 8'h00);
    rchk("mon src", IDX_MON_SRC, 8'h00);
    rchk("mon en", IDX_MON_EN, 8'h00);
    rchk("mon src2", IDX_MON_SRC2, 8'h00);
  endtask : t_reset_values

  task automatic t_mode_override();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, IDX_TX_MODE, 32'hDC | m);
      settle();
      chk("arrangement", arr, m[1:0]);
      chk("map select override", map_sel, 1'b0);
      rchk("tx mode rb", IDX_TX_MODE, 8'hC0 | m[7:0]);
    end
    apb(1'b1, IDX_TX_MODE, 32'h20);
    settle();
    chk("map select strap", map_sel, 1'b1);
  endtask : t_mode_override

  task automatic t_swing_ports();
    apb(1'b1, IDX_SWING, {24'h0, 6'h0, SWING_375MV});
    apb(1'b1, IDX_PORT_SEL, 32'hFF);
    apb(1'b1, IDX_SWING, 32'hA6);
    settle();
    chk("swing port0", sw0, 8'h03);
    chk("swing port1", sw1, 8'hA6);
    rchk("port sel", IDX_PORT_SEL, 8'h01);
    pstrb <= 4'hE;
    apb(1'b1, IDX_SWING, 32'h11);
    pstrb <= 4'hF;
    rchk("swing strobe off", IDX_SWING, 8'hA6);
    apb(1'b1, IDX_PORT_SEL, 32'h0);
    rchk("swing port0 rb", IDX_SWING, 8'h03);
  endtask : t_swing_ports

  // Sets both lanes, waits and compares the monitor output.
  task automatic mon(input logic l0, input logic l1, input logic exp);
    lane0 <= l0;
    lane1 <= l1;
    settle();
    chk("monitor out", mon_out, exp);
  endtask : mon

  task automatic t_monitor();
    mon(1'b1, 1'b1, 1'b0);
    apb(1'b1, IDX_MON_EN, 32'hFF);
    rchk("mon en rb", IDX_MON_EN, 8'h08);
    chk("monitor enable on", mon_en, 1'b1);
    mon(1'b1, 1'b0, 1'b1);
    apb(1'b1, IDX_MON_SRC, 32'hFF);
    rchk("mon src rb", IDX_MON_SRC, 8'h80);
    mon(1'b1, 1'b0, 1'b0);
    mon(1'b0, 1'b1, 1'b1);
    apb(1'b1, IDX_MON_SRC2, 32'hFD);
    rchk("mon src2 rb", IDX_MON_SRC2, 8'h04);
    apb(1'b1, IDX_MON_SRC, 32'h7F);
    apb(1'b1, IDX_MON_SRC2, {29'h0, FIELD_LANE0, 1'b0});
    mon(1'b1, 1'b0, 1'b1);
    apb(1'b1, IDX_MON_SRC2, {29'h0, FIELD_LANE1, 1'b0});
    apb(1'b1, IDX_MON_SRC, 32'h80);
    mon(1'b1, 1'b0, 1'b0);
    apb(1'b1, IDX_MON_EN, 32'h0);
    mon(1'b0, 1'b1, 1'b0);
  endtask : t_monitor

  task automatic t_unmapped();
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h35, 32'hFF);
    chk("unmapped wr err", {31'h0, err}, 32'h1);
  endtask : t_unmapped

  task automatic t_second_reset();
    strap <= 3'h1;
    repeat (6) @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk("rst arrangement", arr, 2'h1);
    chk("rst map select", map_sel, 1'b0);
    chk("rst swing port1", sw1, 8'h00);
    rchk("rst tx mode", IDX_TX_MODE, 8'h01);
  endtask : t_second_reset

  // Watchdog: the whole sequence needs well under this span.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence: reset for four cycles, then the scenarios.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset_values();
    t_mode_override();
    t_swing_ports();
    t_monitor();
    t_unmapped();
    t_second_reset();
    give_verdict();
  end
endmodule : test_video_output_mode_control_regs
